// >>> common/mch_consts.svh
// Purpose: Constants for the memory card host port controller
// Assumes: 100 MHz clock; times in ns rounded up to whole cycles
// Notes:   Offsets, pin-sample positions and timing counts only
`ifndef MCH_CONSTS_SVH
`define MCH_CONSTS_SVH

// Clock period in ns
`define MCH_CLK_NS        10
// Least time to cycles, rounded up, never below one
`define MCH_CYC_UP(ns)    ((((ns) + `MCH_CLK_NS - 1) / `MCH_CLK_NS) < 1 ? 1 : \
                           (((ns) + `MCH_CLK_NS - 1) / `MCH_CLK_NS))
// Strobe and reset timing in ns
`define MCH_T_SETUP_NS    30
`define MCH_T_PULSE_NS    150
`define MCH_T_HOLD_NS     30
`define MCH_T_RESET_NS    1000
// Configuration registers base in attribute space
`define MCH_CFG_BASE      11'h200
// Positions in the sampled input vector
`define MCH_SY_RDY        16
`define MCH_SY_WAIT       17
`define MCH_SY_ACK        18
`define MCH_SY_WP         19
`define MCH_SY_BVD1       20
`define MCH_SY_BVD2       21
`define MCH_SY_W          22
// IDE data register index
`define MCH_IDE_DATA_REG  3'h0

`endif

// >>> common/mch_pkg.sv
// Purpose: Types for the memory card host port controller
// Assumes: Constants come from mch_consts.svh
// Notes:   Holds enums and the controller state record
`include "mch_consts.svh"
package mch_pkg;

	// Controller states
	typedef enum logic [2:0] {
		ST_STRAP,
		ST_RST,
		ST_INIT,
		ST_IDLE,
		ST_DMAWAIT,
		ST_SETUP,
		ST_PULSE,
		ST_HOLD
	} mch_state_e;

	// Access kinds requested by the user side
	typedef enum logic [2:0] {
		K_MEM,
		K_ATTR,
		K_CFG,
		K_IO,
		K_TASK,
		K_ALT,
		K_DMA
	} mch_kind_e;

	// Whole controller state, registered as one word
	typedef struct packed {
		mch_state_e              state;      // Sequencer state
		logic [7:0]              cnt;        // Phase down-counter
		logic                    ide;        // Latched mode strap
		logic                    wr;         // Current access writes
		mch_kind_e               kind;       // Current access kind
		logic [1:0]              size;       // Lane selection
		logic [`MCH_SY_W-1:0]    syn1;       // First sampling stage
		logic [`MCH_SY_W-1:0]    syn2;       // Second sampling stage
		logic [10:0]             addr;       // Address pins
		logic [15:0]             dout;       // Write data pins
		logic                    dout_oe_n;  // Data drive, low drives
		logic                    ce1_n;      // Even or CS0 select
		logic                    ce2_n;      // Odd or CS1 select
		logic                    pin9_n;     // Output enable or mode select
		logic                    we_n;       // Memory write strobe
		logic                    iord_n;     // I/O read strobe
		logic                    iowr_n;     // I/O write strobe
		logic                    pin44_n;    // Register select or DMA acknowledge
		logic                    rst;        // Card reset pin
		logic                    rsp_v;      // Response pulse
		logic [15:0]             rdata;      // Captured read data
		logic                    inpack;     // Input acknowledge seen
		logic                    iois16;     // Wide port seen
		logic                    rdy;        // Command port ready
		logic                    stat_rdy;   // Card ready status
		logic                    irq;        // Interrupt status
		logic                    stschg;     // Status change status
		logic                    wp;         // Write protect status
	} mch_st_s;

endpackage

// >>> design/mch_host.sv
// Purpose: Host-side controller driving a memory card in PC Card or IDE mode
// Assumes: All card pins are asynchronous; strobes timed from clk counts
// Notes:   One access at a time; pin outputs come from flip-flops, except cable select, which comes from MASTER
`include "mch_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module mch_host #(
	parameter int unsigned RST_CYC = `MCH_CYC_UP(`MCH_T_RESET_NS),
	parameter bit          MASTER  = 1'b1
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              arst_n,
	// Configuration
	input  wire logic              ide_mode_req,
	input  wire logic              pc_io_mode,
	// Command port
	input  wire logic              cmd_valid,
	input  wire mch_pkg::mch_kind_e cmd_kind,
	input  wire logic              cmd_write,
	input  wire logic [1:0]        cmd_size,
	input  wire logic [10:0]       cmd_addr,
	input  wire logic [15:0]       cmd_wdata,
	output logic                   cmd_ready,
	// Response port
	output logic                   rsp_valid,
	output logic [15:0]            rsp_rdata,
	output logic                   rsp_inpack,
	output logic                   rsp_iois16,
	// Status
	output logic                   card_ready,
	output logic                   card_irq,
	output logic                   card_stschg,
	output logic                   card_wp,
	// Card pins
	output logic [10:0]            pin_addr,
	input  wire logic [15:0]       pin_data_i,
	output logic [15:0]            pin_data_o,
	output logic                   pin_data_oe_n,
	output logic                   pin_ce1_n,
	output logic                   pin_ce2_n,
	output logic                   pin_oe_ide_mode_select_n_n,
	output logic                   pin_we_n,
	output logic                   pin_iord_n,
	output logic                   pin_iowr_n,
	output logic                   pin_reg_dmack_n,
	output logic                   pin_reset,
	output logic                   pin_csel_n,
	input  wire logic              pin_rdy_irq,
	input  wire logic              pin_wait,
	input  wire logic              pin_ack_dmarq,
	input  wire logic              pin_wp_iois16,
	input  wire logic              pin_bvd1,
	input  wire logic              pin_bvd2
);

	// Strobe phase and reset lengths in cycles
	localparam logic [7:0] SETUP_C = 8'(`MCH_CYC_UP(`MCH_T_SETUP_NS));
	localparam logic [7:0] PULSE_C = 8'(`MCH_CYC_UP(`MCH_T_PULSE_NS));
	localparam logic [7:0] HOLD_C  = 8'(`MCH_CYC_UP(`MCH_T_HOLD_NS));
	localparam logic [7:0] RST_C   = 8'(RST_CYC);

	// Whole module state, one record from the package
	mch_pkg::mch_st_s q;  // Registered state
	mch_pkg::mch_st_s d;  // Next state

	// Next-state logic
	always_comb begin
		d = q;
		d.rsp_v = 1'b0;
		// Two-stage sampling of card inputs
		d.syn1 = {pin_bvd2, pin_bvd1, pin_wp_iois16, pin_ack_dmarq, pin_wait, pin_rdy_irq,
			pin_data_i};
		d.syn2 = q.syn1;
		// Status decode, pin meaning depends on mode
		d.stat_rdy = !q.ide && !pc_io_mode && q.syn2[`MCH_SY_RDY];
		d.irq = q.ide ? q.syn2[`MCH_SY_RDY]
			: (pc_io_mode && !q.syn2[`MCH_SY_RDY]);
		d.stschg = !q.ide && pc_io_mode && !q.syn2[`MCH_SY_BVD1];
		d.wp = !q.ide && !pc_io_mode && q.syn2[`MCH_SY_WP];
		case (q.state)
			// Latch mode strap once, then hold the select pin steady
			mch_pkg::ST_STRAP: begin
				d.ide = ide_mode_req;
				d.pin9_n = !ide_mode_req;
				d.rst = !ide_mode_req;
				d.cnt = RST_C;
				d.state = mch_pkg::ST_RST;
			end
			// Card reset pulse, polarity by mode
			mch_pkg::ST_RST: begin
				if (q.cnt <= 8'h01) begin
					d.rst = q.ide;
					d.state = mch_pkg::ST_INIT;
				end else begin
					d.cnt = q.cnt - 8'h01;
				end
			end
			// PC modes wait for ready high; IDE proceeds at once
			mch_pkg::ST_INIT: begin
				if (q.ide || q.syn2[`MCH_SY_RDY]) begin
					d.state = mch_pkg::ST_IDLE;
				end
			end
			// Accept a command and present address and selects
			mch_pkg::ST_IDLE: begin
				if (cmd_valid) begin
					d.kind = cmd_kind;
					d.wr = cmd_write;
					d.size = cmd_size;
					d.dout = cmd_wdata;
					d.cnt = SETUP_C;
					d.state = mch_pkg::ST_SETUP;
					if (q.ide) begin
						d.addr = {8'h00, cmd_addr[2:0]};
						d.ce1_n = (cmd_kind != mch_pkg::K_TASK);
						d.ce2_n = (cmd_kind != mch_pkg::K_ALT);
						// Task registers byte-wide except data register
						d.size = (cmd_kind == mch_pkg::K_DMA
							|| cmd_addr[2:0] == `MCH_IDE_DATA_REG) ? 2'h1 : 2'h0;
						if (cmd_kind == mch_pkg::K_DMA) begin
							d.ce1_n = 1'b1;
							d.ce2_n = 1'b1;
							d.state = mch_pkg::ST_DMAWAIT;
						end
					end else begin
						d.addr = (cmd_kind == mch_pkg::K_CFG)
							? `MCH_CFG_BASE + cmd_addr : cmd_addr;
						// Byte, word, or odd-only lane selection
						d.ce1_n = (cmd_size == 2'h2);
						d.ce2_n = (cmd_size == 2'h0);
						d.pin44_n = (cmd_kind == mch_pkg::K_MEM);
					end
					if (cmd_write) begin
						d.dout_oe_n = 1'b0;
						if (cmd_size == 2'h2 && !q.ide) begin
							d.dout = {cmd_wdata[7:0], 8'h00};
						end
					end
				end
			end
			// Wait for DMA request before acknowledging
			mch_pkg::ST_DMAWAIT: begin
				if (q.syn2[`MCH_SY_ACK]) begin
					d.pin44_n = 1'b0;
					d.state = mch_pkg::ST_SETUP;
				end
			end
			// Address setup, then open the strobe
			mch_pkg::ST_SETUP: begin
				if (q.cnt <= 8'h01) begin
					d.cnt = PULSE_C;
					d.state = mch_pkg::ST_PULSE;
					// IDE keeps the mode pin low, so every IDE access uses I/O strobes
					if (!q.ide && (q.kind == mch_pkg::K_MEM || q.kind == mch_pkg::K_ATTR
						|| q.kind == mch_pkg::K_CFG)) begin
						d.pin9_n = q.wr;
						d.we_n = !q.wr;
					end else begin
						d.iord_n = q.wr;
						d.iowr_n = !q.wr;
					end
				end else begin
					d.cnt = q.cnt - 8'h01;
				end
			end
			// Fixed pulse; card never extends it
			mch_pkg::ST_PULSE: begin
				if (q.cnt <= 8'h01) begin
					d.cnt = HOLD_C;
					d.state = mch_pkg::ST_HOLD;
					d.pin9_n = !q.ide;
					d.we_n = 1'b1;
					d.iord_n = 1'b1;
					d.iowr_n = 1'b1;
					d.rdata = (q.size == 2'h1) ? q.syn2[15:0]
						: (q.size == 2'h2) ? {8'h00, q.syn2[15:8]}
						: {8'h00, q.syn2[7:0]};
					d.inpack = !q.ide && !q.wr && q.kind == mch_pkg::K_IO
						&& !q.syn2[`MCH_SY_ACK];
					d.iois16 = !q.ide && q.kind == mch_pkg::K_IO
						&& !q.syn2[`MCH_SY_WP];
				end else begin
					d.cnt = q.cnt - 8'h01;
				end
			end
			// Data still driven past strobe rise, then release
			mch_pkg::ST_HOLD: begin
				if (q.cnt <= 8'h01) begin
					d.dout_oe_n = 1'b1;
					d.ce1_n = 1'b1;
					d.ce2_n = 1'b1;
					d.pin44_n = 1'b1;
					d.rsp_v = 1'b1;
					d.state = mch_pkg::ST_IDLE;
				end else begin
					d.cnt = q.cnt - 8'h01;
				end
			end
			default: begin
				d.state = mch_pkg::ST_STRAP;
			end
		endcase
		d.rdy = (d.state == mch_pkg::ST_IDLE);
	end

	// State register
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			q <= '{state: mch_pkg::ST_STRAP, cnt: 8'h00, ide: 1'b0, wr: 1'b0,
				kind: mch_pkg::K_MEM, size: 2'h0, syn1: '0, syn2: '0, addr: 11'h000,
				dout: 16'h0000,
				dout_oe_n: 1'b1, ce1_n: 1'b1, ce2_n: 1'b1, pin9_n: 1'b1, we_n: 1'b1,
				iord_n: 1'b1, iowr_n: 1'b1, pin44_n: 1'b1, rst: 1'b1, rsp_v: 1'b0,
				rdata: 16'h0000, inpack: 1'b0, iois16: 1'b0, rdy: 1'b0,
				stat_rdy: 1'b0, irq: 1'b0, stschg: 1'b0, wp: 1'b0};
		end else begin
			q <= d;
		end
	end

	// Outputs straight from state, cable select from MASTER
	assign cmd_ready       = q.rdy;
	assign rsp_valid       = q.rsp_v;
	assign rsp_rdata       = q.rdata;
	assign rsp_inpack      = q.inpack;
	assign rsp_iois16      = q.iois16;
	assign card_ready      = q.stat_rdy;
	assign card_irq        = q.irq;
	assign card_stschg     = q.stschg;
	assign card_wp         = q.wp;
	assign pin_addr        = q.addr;
	assign pin_data_o      = q.dout;
	assign pin_data_oe_n   = q.dout_oe_n;
	assign pin_ce1_n       = q.ce1_n;
	assign pin_ce2_n       = q.ce2_n;
	assign pin_oe_ide_mode_select_n_n = q.pin9_n;
	assign pin_we_n        = q.we_n;
	assign pin_iord_n      = q.iord_n;
	assign pin_iowr_n      = q.iowr_n;
	assign pin_reg_dmack_n = q.pin44_n;
	assign pin_reset       = q.rst;
	assign pin_csel_n      = !MASTER;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	a_ide_upper_addr: assert property (q.ide |-> q.addr[10:3] == 8'h00)
		else $error("upper address lines driven in IDE mode");
	a_mode_pin_held: assert property (q.ide && q.state != mch_pkg::ST_STRAP
		|-> !q.pin9_n)
		else $error("mode select not low in IDE mode");
	a_dmack_cs_off: assert property (q.ide && !q.pin44_n |-> q.ce1_n && q.ce2_n)
		else $error("chip select active with DMA acknowledge");
	a_dmack_after_req: assert property (q.ide && $fell(q.pin44_n) |-> $past(q.syn2[`MCH_SY_ACK]))
		else $error("DMA acknowledge without request");
	a_reset_polarity: assert property (q.state == mch_pkg::ST_RST |-> q.rst == !q.ide)
		else $error("card reset wrong polarity");
	a_write_pulse_len: assert property ($fell(q.iowr_n) |-> !q.iowr_n [*8])
		else $error("write strobe too short");
	a_data_hold_rise: assert property ($rose(q.iowr_n) |-> !q.dout_oe_n ##1 !q.dout_oe_n)
		else $error("write data dropped at strobe rise");
	a_reg_low_io: assert property (!q.ide && !(q.iord_n && q.iowr_n) |-> !q.pin44_n)
		else $error("register select high in I/O cycle");
	a_dmack_idle: assert property (q.state == mch_pkg::ST_IDLE |-> q.pin44_n)
		else $error("DMA acknowledge held while idle");

	c_dma_word: cover property (q.ide && !q.pin44_n && !q.iord_n);
	c_io_read: cover property (!q.ide && !q.iord_n ##[1:40] q.rsp_v);
	c_mem_write: cover property (!q.ide && !q.we_n);
	c_init_done: cover property (q.state == mch_pkg::ST_INIT ##1 q.state == mch_pkg::ST_IDLE);

endmodule
`default_nettype wire

// >>> verification/mch_card_model.sv
// Purpose: Card-side model that answers the host port controller
// Assumes: Mode strap comes from the bench; the model is the master device
// Notes:   Undriven data lines show a pattern that toggles every half cycle
`timescale 1ns/1ps
`default_nettype none
module mch_card_model #(
	parameter int INIT = 5  // Init cycles after reset
) (
	// Bench controls
	input  wire logic        clk,
	input  wire logic        ide_mode_req,
	input  wire logic        pc_io_mode,
	input  wire logic        irq,
	input  wire logic        stschg_n,
	input  wire logic        dma_go,
	output logic             bad,
	// Host-driven pins
	input  wire logic [10:0] pin_addr,
	input  wire logic [15:0] pin_data_o,
	input  wire logic        pin_data_oe_n,
	input  wire logic        pin_ce1_n,
	input  wire logic        pin_ce2_n,
	input  wire logic        pin_oe_ide_mode_select_n_n,
	input  wire logic        pin_we_n,
	input  wire logic        pin_iord_n,
	input  wire logic        pin_iowr_n,
	input  wire logic        pin_reg_dmack_n,
	input  wire logic        pin_reset,
	input  wire logic        pin_csel_n,
	// Card-driven pins
	output logic [15:0]      pin_data_i,
	output logic             pin_rdy_irq,
	output logic             pin_wait,
	output logic             pin_ack_dmarq,
	output logic             pin_wp_iois16,
	output logic             pin_bvd1,
	output logic             pin_bvd2
);
	logic [7:0]  m8 [0:4095];  // Common below, attribute above
	logic [7:0]  t8 [0:15];    // Task file and alternate registers
	logic [15:0] dreg;         // Data register
	logic [15:0] pat;          // Undriven pattern
	logic [15:0] dq;           // Card read data
	logic [11:0] e;            // Even byte index
	logic        ide, rst, rdy, drv, rd, sel;
	logic        drq = 1'b0;   // Pending request
	int          cnt;
	assign ide = ide_mode_req;
	assign pat = {16{clk}} ^ 16'h5A5A;
	assign rst = ide ? !pin_reset : pin_reset;
	assign e = {!pin_reg_dmack_n, pin_addr[10:1], 1'b0};
	assign rd = !pin_oe_ide_mode_select_n_n || !pin_iord_n;
	assign sel = !pin_ce1_n || !pin_ce2_n;
	initial bad = 1'b0;
	// Init sequence holds ready low
	always @(posedge clk) begin
		if (rst) begin
			cnt <= 0;
			rdy <= 1'b0;
		end else if (cnt < INIT) begin
			cnt <= cnt + 1;
		end else begin
			rdy <= 1'b1;
		end
	end
	// Request stands until acknowledge
	always @(posedge clk) begin
		if (dma_go)
			drq <= 1'b1;
		else if (!pin_reg_dmack_n)
			drq <= 1'b0;
	end
	// Host obligations in IDE mode
	always @(posedge clk) begin
		if (ide && !rst && sel && (!pin_reg_dmack_n || pin_addr[10:3] != 8'h00))
			bad <= 1'b1;
	end
	// Read lanes per mode
	always_comb begin
		dq = pat;
		if (ide) begin
			drv = !pin_iord_n && (sel || !pin_reg_dmack_n);
			if (!pin_reg_dmack_n || (!pin_ce1_n && pin_addr[2:0] == 3'h0))
				dq = dreg;
			else
				dq[7:0] = t8[{!pin_ce2_n, pin_addr[2:0]}];
		end else begin
			drv = rd && sel;
			if (!pin_ce1_n && pin_ce2_n)
				dq[7:0] = m8[{!pin_reg_dmack_n, pin_addr}];
			if (!pin_ce2_n)
				dq[15:8] = m8[e | 12'h001];
			if (!pin_ce1_n && !pin_ce2_n)
				dq[7:0] = m8[e];
		end
	end
	assign pin_data_i = !pin_data_oe_n ? pin_data_o : (drv ? dq : pat);
	// Capture on strobe rise
	always @(posedge pin_we_n or posedge pin_iowr_n) begin
		if (ide) begin
			if (!pin_reg_dmack_n || (!pin_ce1_n && pin_addr[2:0] == 3'h0))
				dreg <= pin_data_i;
			else if (sel)
				t8[{!pin_ce2_n, pin_addr[2:0]}] <= pin_data_i[7:0];
		end else if (!pin_ce1_n && pin_ce2_n) begin
			m8[{!pin_reg_dmack_n, pin_addr}] <= pin_data_i[7:0];
		end else if (!pin_ce2_n) begin
			m8[e | 12'h001] <= pin_data_i[15:8];
			if (!pin_ce1_n)
				m8[e] <= pin_data_i[7:0];
		end
	end
	// Status pins
	assign pin_rdy_irq = ide ? irq : (pc_io_mode ? !irq : rdy);
	assign pin_wp_iois16 = pc_io_mode ? (pin_ce1_n || pin_addr[3]) : !rdy;
	assign pin_bvd1 = pc_io_mode ? stschg_n : 1'b1;
	assign pin_bvd2 = 1'b1;
	assign pin_wait = 1'b1;
	assign pin_ack_dmarq = ide ? (pin_csel_n ? pat[0] : drq)
		: (pc_io_mode ? (pin_ce1_n || pin_iord_n) : 1'b1);
endmodule
`default_nettype wire

// >>> verification/test_mch_host.sv
// Purpose: Self-checking bench for the memory card host port controller
// Assumes: Card model answers all modes; short reset count
// Notes:   Inputs change on the falling edge
`timescale 1ns/1ps
`default_nettype none
module test_mch_host;
	logic clk = 1'b0, arst_n = 1'b0, ide_mode_req = 1'b0, pc_io_mode = 1'b0;
	logic cmd_valid = 1'b0, cmd_write = 1'b0;
	mch_pkg::mch_kind_e cmd_kind = mch_pkg::K_MEM;
	logic [1:0]  cmd_size = 2'h0;
	logic [10:0] cmd_addr = 11'h000, pin_addr;
	logic [15:0] cmd_wdata = 16'h0000, rsp_rdata, pin_data_i, pin_data_o;
	logic cmd_ready, rsp_valid, rsp_inpack, rsp_iois16;
	logic card_ready, card_irq, card_stschg, card_wp;
	logic pin_data_oe_n, pin_ce1_n, pin_ce2_n, pin_oe_ide_mode_select_n_n, pin_we_n;
	logic pin_iord_n, pin_iowr_n, pin_reg_dmack_n, pin_reset, pin_csel_n;
	logic pin_rdy_irq, pin_wait, pin_ack_dmarq, pin_wp_iois16, pin_bvd1, pin_bvd2;
	logic irq = 1'b0, stschg_n = 1'b1, dma_go = 1'b0, bad;
	int   fails = 0, comparisons = 0;
	mch_host #(.RST_CYC(2)) mch_host_i (.clk, .arst_n, .ide_mode_req, .pc_io_mode,
		.cmd_valid, .cmd_kind, .cmd_write, .cmd_size, .cmd_addr, .cmd_wdata, .cmd_ready,
		.rsp_valid, .rsp_rdata, .rsp_inpack, .rsp_iois16, .card_ready, .card_irq,
		.card_stschg, .card_wp, .pin_addr, .pin_data_i, .pin_data_o, .pin_data_oe_n,
		.pin_ce1_n, .pin_ce2_n, .pin_oe_ide_mode_select_n_n, .pin_we_n, .pin_iord_n, .pin_iowr_n,
		.pin_reg_dmack_n, .pin_reset, .pin_csel_n, .pin_rdy_irq, .pin_wait,
		.pin_ack_dmarq, .pin_wp_iois16, .pin_bvd1, .pin_bvd2);
	mch_card_model mch_card_model_i (.clk, .ide_mode_req, .pc_io_mode, .irq, .stschg_n,
		.dma_go, .bad, .pin_addr, .pin_data_o, .pin_data_oe_n, .pin_ce1_n, .pin_ce2_n,
		.pin_oe_ide_mode_select_n_n, .pin_we_n, .pin_iord_n, .pin_iowr_n, .pin_reg_dmack_n,
		.pin_reset, .pin_csel_n, .pin_data_i, .pin_rdy_irq, .pin_wait, .pin_ack_dmarq,
		.pin_wp_iois16, .pin_bvd1, .pin_bvd2);
	// Free-running clock
	always #5 clk = ~clk;
	// Compare and count
	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] x);
		comparisons++;
		if (s !== x) begin
			fails++;
			$display("ERROR %s expected %h seen %h", n, x, s);
		end
	endtask
	// Verdict and end of run
	task automatic stop_test();
		$display("Comparisons %0d mismatches %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Bounded wait for a flag at falling edges
	task automatic wait_hi(ref logic f);
		int n;
		n = 0;
		while (f !== 1'b1 && n < 500) begin
			@(negedge clk);
			n++;
		end
		if (n >= 500)
			fails++;
	endtask
	// One access through the command port
	task automatic acc(input mch_pkg::mch_kind_e k, input logic w, input logic [1:0] sz,
		input logic [10:0] ad, input logic [15:0] wd);
		wait_hi(cmd_ready);
		cmd_valid = 1'b1;
		cmd_kind = k;
		cmd_write = w;
		cmd_size = sz;
		cmd_addr = ad;
		cmd_wdata = wd;
		@(negedge clk);
		cmd_valid = 1'b0;
		wait_hi(rsp_valid);
	endtask
	// Reset with mode strap
	task automatic rst(input logic ide);
		arst_n = 1'b0;
		ide_mode_req = ide;
		pc_io_mode = 1'b0;
		repeat (12) @(negedge clk);
		chk("reset held", pin_reset, 1);
		arst_n = 1'b1;
		@(negedge clk);
		chk("reset polarity", pin_reset, !ide);
		chk("mode strap", pin_oe_ide_mode_select_n_n, !ide);
		chk("ready in init", card_ready, 0);
		wait_hi(cmd_ready);
		chk("cable select", pin_csel_n, 0);
	endtask
	// Memory mode lanes and spaces
	task automatic t_mem();
		rst(1'b0);
		chk("ready", card_ready, 1);
		chk("write protect", card_wp, 0);
		acc(mch_pkg::K_MEM, 1, 1, 11'h010, 16'hA1B2);
		acc(mch_pkg::K_MEM, 1, 0, 11'h012, 16'h0033);
		acc(mch_pkg::K_MEM, 1, 2, 11'h012, 16'h0044);
		acc(mch_pkg::K_MEM, 0, 1, 11'h012, 16'h0000);
		chk("word lanes", rsp_rdata, 16'h4433);
		acc(mch_pkg::K_MEM, 0, 0, 11'h011, 16'h0000);
		chk("odd byte low lane", rsp_rdata, 16'h00A1);
		acc(mch_pkg::K_CFG, 1, 0, 11'h004, 16'h005A);
		acc(mch_pkg::K_ATTR, 0, 0, 11'h204, 16'h0000);
		chk("config space", rsp_rdata, 16'h005A);
		chk("status change", card_stschg, 0);
		$display("Test memory mode done");
	endtask
	// I/O mode ports and status
	task automatic t_io();
		pc_io_mode = 1'b1;
		irq = 1'b1;
		stschg_n = 1'b0;
		acc(mch_pkg::K_IO, 1, 1, 11'h002, 16'hC3D4);
		acc(mch_pkg::K_IO, 0, 1, 11'h002, 16'h0000);
		chk("io word", rsp_rdata, 16'hC3D4);
		chk("input ack", rsp_inpack, 1);
		chk("wide port", rsp_iois16, 1);
		acc(mch_pkg::K_IO, 1, 0, 11'h00B, 16'h0066);
		acc(mch_pkg::K_IO, 0, 0, 11'h00B, 16'h0000);
		chk("io byte", rsp_rdata, 16'h0066);
		chk("narrow port", rsp_iois16, 0);
		chk("status change", card_stschg, 1);
		chk("irq low active", card_irq, 1);
		irq = 1'b0;
		stschg_n = 1'b1;
		repeat (4) @(negedge clk);
		chk("irq idle", card_irq, 0);
		chk("status idle", card_stschg, 0);
		$display("Test io mode done");
	endtask
	// IDE registers and DMA
	task automatic t_ide();
		rst(1'b1);
		acc(mch_pkg::K_TASK, 1, 0, 11'h002, 16'h0077);
		acc(mch_pkg::K_ALT, 1, 0, 11'h006, 16'h0088);
		acc(mch_pkg::K_TASK, 1, 0, 11'h000, 16'hBEEF);
		acc(mch_pkg::K_TASK, 0, 0, 11'h002, 16'h0000);
		chk("task byte", rsp_rdata, 16'h0077);
		acc(mch_pkg::K_ALT, 0, 0, 11'h006, 16'h0000);
		chk("alternate reg", rsp_rdata, 16'h0088);
		dma_go = 1'b1;
		@(negedge clk);
		dma_go = 1'b0;
		acc(mch_pkg::K_DMA, 0, 0, 11'h000, 16'h0000);
		chk("dma word", rsp_rdata, 16'hBEEF);
		chk("host pin use", bad, 0);
		chk("dmack released", pin_reg_dmack_n, 1);
		irq = 1'b1;
		repeat (4) @(negedge clk);
		chk("irq high active", card_irq, 1);
		$display("Test ide mode done");
	endtask
	// Main sequence
	initial begin
		@(negedge clk);
		t_mem();
		t_io();
		t_ide();
		stop_test();
	end
	// Watchdog, about forty times the expected run
	initial begin
		#200000;
		fails++;
		stop_test();
	end
endmodule
`default_nettype wire
